/* parallel_io_ports.sv */
// four general-purpose ports with direction control, keyscan interrupt and shared pins
// assumes pins already synchronous to clk; serial, timer and converter live elsewhere
`timescale 1ns/1ps
`include "parallel_io_cfg.svh"

module parallel_io_ports #(
  parameter int WIDTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire parallel_io_pkg::bus_req_t bus,
  output logic [WIDTH-1:0]              rdata,
  input  wire logic [WIDTH-1:0]         pa_in,
  output logic [WIDTH-1:0]              pa_out,
  output logic [WIDTH-1:0]              pa_oe_n,
  output logic [WIDTH-1:0]              pa_pullup,
  input  wire logic [WIDTH-1:0]         pb_in,
  output logic [WIDTH-1:0]              pb_out,
  output logic [WIDTH-1:0]              pb_oe_n,
  input  wire logic [WIDTH-1:0]         pc_in,
  output logic [WIDTH-1:0]              pc_out,
  output logic [WIDTH-1:0]              pc_oe_n,
  input  wire logic [WIDTH-1:0]         pd_in,
  output logic [WIDTH-1:0]              pd_out,
  output logic [WIDTH-1:0]              pd_oe_n,
  input  wire parallel_io_pkg::serial_ctl_t serial,
  input  wire logic                     converter_power_on,
  input  wire logic                     keyscan_option,
  output logic                          sdi_level,
  output logic                          sck_level,
  output logic                          timer_shared_input_pin,
  output logic                          ext_irq_n,
  output logic                          irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    parallel_io_pkg::port_regs_t a;
    parallel_io_pkg::port_regs_t b;
    parallel_io_pkg::port_regs_t c;
    parallel_io_pkg::port_regs_t d;
    logic [WIDTH-1:0] rdata;
    logic [WIDTH-1:0] pa_out, pa_oe_n, pa_pullup;
    logic [WIDTH-1:0] pb_out, pb_oe_n;
    logic [WIDTH-1:0] pc_out, pc_oe_n;
    logic [WIDTH-1:0] pd_out, pd_oe_n;
    logic [WIDTH-1:0] pa_prev;
    logic [1:0]       irq_status;
    logic [1:0]       irq_enable;
    logic             sdi, sck, tin, ext_irq_n, irq;
  } state_t;

  state_t q, d;

  // read view: latch where output, pin where input
  function automatic logic [WIDTH-1:0] port_view(input logic [WIDTH-1:0] dir,
                                                 input logic [WIDTH-1:0] lat,
                                                 input logic [WIDTH-1:0] pin);
    port_view = (dir & lat) | (~dir & pin);
  endfunction : port_view

  logic [WIDTH-1:0] key_fall;
  logic [WIDTH-1:0] b_dir_eff;
  logic [WIDTH-1:0] b_out_eff;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = '0;
    // serial takeover of the 3-bit port
    b_dir_eff = q.b.dir;
    b_out_eff = q.b.data;
    if (serial.enable) begin
      b_dir_eff[`PIO_BIT_SDO] = 1'b1;
      b_out_eff[`PIO_BIT_SDO] = serial.sdo;
      b_dir_eff[`PIO_BIT_SDI] = 1'b0;
      b_dir_eff[`PIO_BIT_SCK] = serial.master;
      b_out_eff[`PIO_BIT_SCK] = serial.sck_out;
    end
    // writes: registers stay reachable even while serial or converter own pins
    if (bus.wr) begin
      case (bus.addr)
        `PIO_OFS_A_DATA: d.a.data = bus.wdata;
        `PIO_OFS_B_DATA: d.b.data = bus.wdata & `PIO_MASK_B;
        `PIO_OFS_C_DATA: d.c.data = bus.wdata;
        `PIO_OFS_D_DATA: d.d.data = bus.wdata & `PIO_MASK_D_DIR;
        `PIO_OFS_A_DIR:  d.a.dir  = bus.wdata;
        `PIO_OFS_B_DIR:  d.b.dir  = bus.wdata & `PIO_MASK_B;
        `PIO_OFS_C_DIR:  d.c.dir  = bus.wdata;
        `PIO_OFS_D_DIR:  d.d.dir  = bus.wdata & `PIO_MASK_D_DIR;
        `PIO_OFS_IRQ_ENABLE: d.irq_enable = bus.wdata[1:0];
        default: ;
      endcase
    end
    // reads answer one cycle later; unmapped reads give zero
    if (bus.rd) begin
      case (bus.addr)
        `PIO_OFS_A_DATA: d.rdata = port_view(q.a.dir, q.a.data, pa_in);
        `PIO_OFS_B_DATA: d.rdata = port_view(q.b.dir, q.b.data, pb_in) & `PIO_MASK_B;
        `PIO_OFS_C_DATA: d.rdata = port_view(q.c.dir, q.c.data, pc_in);
        `PIO_OFS_D_DATA: d.rdata = port_view(q.d.dir, q.d.data, pd_in) & `PIO_MASK_D_IN;
        `PIO_OFS_A_DIR:  d.rdata = q.a.dir;
        `PIO_OFS_B_DIR:  d.rdata = q.b.dir;
        `PIO_OFS_C_DIR:  d.rdata = q.c.dir;
        `PIO_OFS_D_DIR:  d.rdata = q.d.dir;
        `PIO_OFS_IRQ_STATUS: d.rdata = {6'h00, q.irq_status};
        `PIO_OFS_IRQ_ENABLE: d.rdata = {6'h00, q.irq_enable};
        default: d.rdata = '0;
      endcase
    end
    // pin drivers; oe low means driving; twenty-one usable lines in all, twenty of them drivable
    // outputs pass through one more flop so every pin comes straight from a register
    d.pa_out  = q.a.data;
    d.pa_oe_n = ~q.a.dir;
    d.pb_out  = b_out_eff & `PIO_MASK_B;
    d.pb_oe_n = ~(b_dir_eff & `PIO_MASK_B);
    d.pc_out  = q.c.data;
    d.pc_oe_n = ~q.c.dir;
    d.pd_out  = q.d.data & `PIO_MASK_D_DIR;
    d.pd_oe_n = ~(q.d.dir & `PIO_MASK_D_DIR); // bit 7 never driven
    d.pa_pullup = keyscan_option ? ~q.a.dir : '0;
    // keyscan: falling edge on an input pin of the first port
    // output pins are masked out so a latch write never looks like a key press
    key_fall = q.pa_prev & ~pa_in & ~q.a.dir;
    d.pa_prev = pa_in;
    d.ext_irq_n = ~(keyscan_option & (|key_fall));
    d.sdi = pb_in[`PIO_BIT_SDI];
    d.sck = pb_in[`PIO_BIT_SCK];
    d.tin = pd_in[`PIO_BIT_D_IN];
    // sticky events: bit0 keyscan edge, bit1 converter port write while on; set beats clear
    if (bus.wr && bus.addr == `PIO_OFS_IRQ_CLEAR)
      d.irq_status = q.irq_status & ~bus.wdata[1:0];
    if (keyscan_option && |key_fall)
      d.irq_status[0] = 1'b1;
    if (converter_power_on && bus.wr &&
        (bus.addr == `PIO_OFS_C_DATA || bus.addr == `PIO_OFS_C_DIR))
      d.irq_status[1] = 1'b1;
    d.irq = |(d.irq_status & d.irq_enable);
    // reset: direction cleared, data latches untouched
    // pins float to the board until software sets directions again
    // latches are left out on purpose: their value must survive a reset
    if (!rstn) begin
      d.a.dir = `PIO_DIR_RESET;
      d.b.dir = `PIO_DIR_RESET;
      d.c.dir = `PIO_DIR_RESET;
      d.d.dir = `PIO_DIR_RESET;
      d.rdata = '0;
      d.pa_oe_n = '1;
      d.pb_oe_n = '1;
      d.pc_oe_n = '1;
      d.pd_oe_n = '1;
      d.pa_out = '0;
      d.pb_out = '0;
      d.pc_out = '0;
      d.pd_out = '0;
      d.pa_pullup = '0;
      d.pa_prev = '0;
      d.irq_status = `PIO_IRQ_RESET;
      d.irq_enable = `PIO_IRQ_RESET;
      d.sdi = 1'b0;
      d.sck = 1'b0;
      d.tin = 1'b0;
      d.ext_irq_n = 1'b1;
      d.irq = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    q <= d;
  end

  assign rdata     = q.rdata;
  assign pa_out    = q.pa_out;
  assign pa_oe_n   = q.pa_oe_n;
  assign pa_pullup = q.pa_pullup;
  assign pb_out    = q.pb_out;
  assign pb_oe_n   = q.pb_oe_n;
  assign pc_out    = q.pc_out;
  assign pc_oe_n   = q.pc_oe_n;
  assign pd_out    = q.pd_out;
  assign pd_oe_n   = q.pd_oe_n;
  assign sdi_level = q.sdi;
  assign sck_level = q.sck;
  assign timer_shared_input_pin = q.tin;
  assign ext_irq_n = q.ext_irq_n;
  assign irq       = q.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // properties look at registered outputs one edge after their cause, except the input write check, which waits two
  // latch contents are unknown until written, so no check compares them blindly

  // reset turns every pin into an input
  chk_reset_dir_clear: assert property (@(posedge clk)
    !rstn |=> (pa_oe_n == '1 && pb_oe_n == '1 && pc_oe_n == '1 && pd_oe_n == '1))
    else $error("direction not cleared by reset");

  // reset also quiets read data, pullups and both requests
  chk_reset_quiet: assert property (@(posedge clk)
    !rstn |=> (rdata == '0 && !irq && ext_irq_n && pa_pullup == '0))
    else $error("outputs not quiet after reset");

  // a reset entered mid-run leaves the latches of the first and small ports alone
  chk_data_kept_reset: assert property (@(posedge clk)
    (!rstn && $past(rstn) && !bus.wr) |=> (q.a.data == $past(q.a.data) && q.d.data == $past(q.d.data)))
    else $error("data latch changed by reset");

  // first port enables follow its direction bits
  chk_dir_drives_pin: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> pa_oe_n == ~$past(q.a.dir))
    else $error("pin enable not following direction");

  // converter port enables follow its direction bits
  chk_c_dir_drives: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> pc_oe_n == ~$past(q.c.dir))
    else $error("converter port enable not following direction");

  // data read mixes latch and pin bit by bit
  chk_read_mix_view: assert property (@(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == `PIO_OFS_A_DATA) |=> rdata == $past((q.a.dir & q.a.data) | (~q.a.dir & pa_in)))
    else $error("port read view wrong");

  // read data stands only in the cycle after a strobe
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !bus.rd |=> rdata == '0)
    else $error("read data outside its cycle");

  // a data write lands in the latch
  chk_write_stores: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && bus.addr == `PIO_OFS_C_DATA) |=> q.c.data == $past(bus.wdata))
    else $error("data write not stored");

  // a data write to input pins leaves them undriven
  chk_input_write_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && bus.addr == `PIO_OFS_A_DATA && q.a.dir == '0) |=> ##1 pa_oe_n == '1)
    else $error("data write drove an input pin");

  // direction written, one idle cycle, then read back
  chk_dir_readback: assert property (@(posedge clk) disable iff (!rstn)
    (bus.wr && bus.addr == `PIO_OFS_A_DIR) ##1 !bus.wr ##1 (bus.rd && bus.addr == `PIO_OFS_A_DIR)
    |=> rdata == $past(bus.wdata, 3))
    else $error("direction readback wrong");

  // input-only bit reads the pin, other unused bits read zero
  chk_d_in_read: assert property (@(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == `PIO_OFS_D_DATA) |=> (rdata[7] == $past(pd_in[7]) && rdata[6] == 1'b0 && rdata[4:0] == 5'h00))
    else $error("input-only bit read wrong");

  // the input-only pin is never driven
  chk_d7_never_driven: assert property (@(posedge clk) disable iff (!rstn)
    pd_oe_n[`PIO_BIT_D_IN])
    else $error("input-only pin driven");

  // timer copy of the shared input tracks the pin
  chk_tin_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> timer_shared_input_pin == $past(pd_in[`PIO_BIT_D_IN]))
    else $error("timer input copy stale");

  // with the serial port off the 3-bit port is plain gpio
  chk_gpio_when_off: assert property (@(posedge clk) disable iff (!rstn)
    !serial.enable |=> pb_oe_n == ~($past(q.b.dir) & `PIO_MASK_B))
    else $error("3-bit port not plain gpio");

  // registers of the 3-bit port stay writable while serial runs
  chk_regs_reachable: assert property (@(posedge clk) disable iff (!rstn)
    (serial.enable && bus.wr && bus.addr == `PIO_OFS_B_DIR) |=> q.b.dir == ($past(bus.wdata) & `PIO_MASK_B))
    else $error("3-bit port register locked by serial");

  // serial data input pin is released while serial runs
  chk_sdi_input: assert property (@(posedge clk) disable iff (!rstn)
    serial.enable |=> pb_oe_n[`PIO_BIT_SDI])
    else $error("serial input pin driven");

  // clock pin is driven only as master, from the serial clock
  chk_sck_master: assert property (@(posedge clk) disable iff (!rstn)
    serial.enable |=> ((pb_oe_n[`PIO_BIT_SCK] == !$past(serial.master)) &&
                       (!$past(serial.master) || pb_out[`PIO_BIT_SCK] == $past(serial.sck_out))))
    else $error("serial clock pin wrong");

  // serial logic sees the live data and clock pins
  chk_sdi_follow: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> (sdi_level == $past(pb_in[`PIO_BIT_SDI]) && sck_level == $past(pb_in[`PIO_BIT_SCK])))
    else $error("serial pin copy stale");

  // writing the converter port while it converts is flagged
  chk_converter_flag: assert property (@(posedge clk) disable iff (!rstn)
    (converter_power_on && bus.wr && bus.addr == `PIO_OFS_C_DATA) |=> q.irq_status[1])
    else $error("converter write not flagged");

  // pullups only with the factory option and only on inputs
  chk_pullup_option: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> pa_pullup == ($past(keyscan_option) ? ~$past(q.a.dir) : 8'h00))
    else $error("pullup not following option");

  // a key press pulses the external request
  chk_keyscan_pulse: assert property (@(posedge clk) disable iff (!rstn)
    (keyscan_option && (|(q.pa_prev & ~pa_in & ~q.a.dir))) |=> !ext_irq_n)
    else $error("keyscan edge missed");

  // no external request at all without the option
  chk_keyscan_irq: assert property (@(posedge clk) disable iff (!rstn)
    (!keyscan_option && $past(rstn)) |=> ext_irq_n)
    else $error("keyscan request without option");

  // a key press sets the sticky bit even against a clear
  chk_set_beats_clear: assert property (@(posedge clk) disable iff (!rstn)
    (keyscan_option && (|(q.pa_prev & ~pa_in & ~q.a.dir))) |=> q.irq_status[0])
    else $error("keyscan status lost");

  // interrupt level mirrors enabled status
  chk_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    irq == |(q.irq_status & q.irq_enable))
    else $error("interrupt level wrong");

  // serial output owns bit 5 while serial runs
  chk_sdo_takeover: assert property (@(posedge clk) disable iff (!rstn)
    serial.enable |=> (!pb_oe_n[`PIO_BIT_SDO] && pb_out[`PIO_BIT_SDO] == $past(serial.sdo)))
    else $error("serial output not driving bit 5");

  // unimplemented direction bits read zero
  chk_narrow_zero: assert property (@(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr == `PIO_OFS_B_DIR) |=> rdata[4:0] == 5'h00)
    else $error("unimplemented bits not zero");

  // unmapped and write-only offsets read zero
  chk_unmapped_read: assert property (@(posedge clk) disable iff (!rstn)
    (bus.rd && bus.addr > `PIO_OFS_IRQ_ENABLE) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // missing pins of the 3-bit port are never driven
  chk_b_unused_idle: assert property (@(posedge clk) disable iff (!rstn)
    (pb_oe_n[4:0] == 5'h1F && pb_out[4:0] == 5'h00))
    else $error("unused 3-bit port pin driven");

  // missing pins of the small port are never driven
  chk_d_unused_idle: assert property (@(posedge clk) disable iff (!rstn)
    ((pd_oe_n | 8'h20) == 8'hFF && (pd_out & 8'hDF) == 8'h00))
    else $error("unused small port pin driven");

endmodule : parallel_io_ports

/* parallel_io_cfg.svh */
// constants for the parallel i/o ports: register offsets, bit layout, port widths
// assumes an 8-bit register bus with byte offsets; included by bare name
`ifndef PARALLEL_IO_CFG_SVH
`define PARALLEL_IO_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PIO_OFS_A_DATA 4'h0
`define PIO_OFS_B_DATA 4'h1
`define PIO_OFS_C_DATA 4'h2
`define PIO_OFS_D_DATA 4'h3
`define PIO_OFS_A_DIR  4'h4
`define PIO_OFS_B_DIR  4'h5
`define PIO_OFS_C_DIR  4'h6
`define PIO_OFS_D_DIR  4'h7
`define PIO_OFS_IRQ_STATUS 4'h8
`define PIO_OFS_IRQ_ENABLE 4'h9
`define PIO_OFS_IRQ_CLEAR  4'hA

// ------------------------------------------------------------
// implemented bit masks and reset values
// ------------------------------------------------------------
`define PIO_MASK_B     8'hE0
`define PIO_MASK_D_DIR 8'h20
`define PIO_MASK_D_IN  8'hA0
`define PIO_BIT_SDO    5
`define PIO_BIT_SDI    6
`define PIO_BIT_SCK    7
`define PIO_BIT_D_IN   7
`define PIO_DIR_RESET  8'h00
`define PIO_IRQ_RESET  2'h0

`endif

/* parallel_io_pkg.sv */
// types shared by the parallel i/o ports
// assumes the cfg header supplies all numeric constants
package parallel_io_pkg;

  // ------------------------------------------------------------
  // bus request and per-port register pair
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
  } port_regs_t;

  // serial port view of the 3-bit port
  typedef struct packed {
    logic enable;
    logic master;
    logic sdo;
    logic sck_out;
  } serial_ctl_t;

endpackage : parallel_io_pkg

/* pio_pins.sv */
// board model: the circuits that meet the four ports at their pins
// assumes active-low enables; an undriven pin shows the board's level
`timescale 1ns/1ps
module pio_pins (
  input  wire logic [31:0] out,
  input  wire logic [31:0] oe_n,
  input  wire logic [31:0] ext,
  output logic      [31:0] pin
);
  // a driving port wins over the board, else the board level shows
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pin[i] = oe_n[i] ? ext[i] : out[i];
    end
  end
endmodule : pio_pins

/* test_parallel_io_ports.sv */
// self-checking bench for the four parallel ports
// assumes the cfg header masks; pins closed through the board model
`timescale 1ns/1ps
`include "parallel_io_cfg.svh"
module test_parallel_io_ports;
  logic clk, rstn, kopt, adc_on, sdi, sck, tpin, eirq_n, irq;
  parallel_io_pkg::bus_req_t    bus;
  parallel_io_pkg::serial_ctl_t ser;
  logic [7:0]  rdata, pull, pv, lat[4], dir[4];
  logic [31:0] outs, oen, ext, pins;
  int          mismatches, n_tests, pulses, p;
  int          seed = 32'hB4EFA3B9;

  parallel_io_ports uut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .pa_in(pins[7:0]), .pa_out(outs[7:0]), .pa_oe_n(oen[7:0]), .pa_pullup(pull),
    .pb_in(pins[15:8]), .pb_out(outs[15:8]), .pb_oe_n(oen[15:8]),
    .pc_in(pins[23:16]), .pc_out(outs[23:16]), .pc_oe_n(oen[23:16]),
    .pd_in(pins[31:24]), .pd_out(outs[31:24]), .pd_oe_n(oen[31:24]),
    .serial(ser), .converter_power_on(adc_on), .keyscan_option(kopt),
    .sdi_level(sdi), .sck_level(sck), .timer_shared_input_pin(tpin),
    .ext_irq_n(eirq_n), .irq(irq));
  pio_pins board (.out(outs), .oe_n(oen), .ext(ext), .pin(pins));

  // clock and interrupt pulse counter
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(negedge eirq_n) if (rstn) pulses++;

  // --------------------------------------------------------
  // model and bus tasks
  // --------------------------------------------------------
  function automatic logic [7:0] dm(int q);
    return q == 1 ? `PIO_MASK_B : q == 3 ? `PIO_MASK_D_DIR : 8'hFF;
  endfunction : dm
  // inputs show the pin, outputs the latch
  function automatic logic [7:0] lvl(int q);
    return (lat[q] & dir[q]) | (ext[q*8+:8] & ~dir[q]);
  endfunction : lvl
  function automatic logic [7:0] exp_rd(int q);
    return lvl(q) & (q == 3 ? `PIO_MASK_D_IN : dm(q));
  endfunction : exp_rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= {a, d, 2'b10};
    @(posedge clk) bus <= '0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) bus <= {a, 8'h00, 2'b01};
    @(posedge clk) bus <= '0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic wd(int q, input logic [7:0] d);
    wr(4'(q), d);
    lat[q] = d & dm(q);
  endtask : wd
  task automatic wdir(int q, input logic [7:0] d);
    wr(4'(4 + q), d);
    dir[q] = d & dm(q);
  endtask : wdir
  task automatic pchk(int q);
    #1 chk(oen[q*8+:8] & dm(q), ~dir[q] & dm(q));
    chk(outs[q*8+:8] & dir[q], lat[q] & dir[q]);
  endtask : pchk
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // watchdog: the whole run needs well under 10k cycles
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end

  // --------------------------------------------------------
  // main sequence
  // --------------------------------------------------------
  initial begin
    rstn = 0; bus = '0; ser = '0; kopt = 0; adc_on = 0; ext = '0;
    repeat (12) @(posedge clk);
    rstn <= 1;
    for (int q = 0; q < 4; q++) begin
      dir[q] = 8'h00;
      rd(4'(4 + q), 8'h00);
      wd(q, 8'($random(seed)));
    end
    $display("test reset done");
    // data first, then direction, so no pin glitches
    for (int k = 0; k < 48; k++) begin
      p = $unsigned($random(seed)) % 4;
      wd(p, 8'($random(seed)));
      wdir(p, 8'($random(seed)));
      ext <= $random(seed);
      repeat (3) @(posedge clk);
      pchk(p);
      pv = lvl(1);
      chk({5'h0, sdi, sck, tpin}, {5'h0, pv[6], pv[7], ext[31]});
      rd(4'(p), exp_rd(p));
      rd(4'(4 + p), dir[p]);
    end
    $display("test random access done");
    // mid-run reset keeps latches but clears directions
    @(posedge clk) rstn <= 0;
    repeat (2) @(posedge clk) rstn <= 1;
    for (int q = 0; q < 4; q++) begin
      dir[q] = 8'h00;
      pchk(q);
      wdir(q, 8'hFF);
      rd(4'(q), exp_rd(q));
    end
    wdir(0, 8'h5A);
    rd(4'h4, dir[0]);
    $display("test second reset done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) ser <= {2'b11, s[0], ~s[0]};
      repeat (3) @(posedge clk);
      #1 chk({outs[15], outs[13], oen[15:13]}, {3'h0, ~s[0], s[0], 3'b010});
      wdir(1, 8'hFF);
      rd(4'h5, dir[1]);
    end
    @(posedge clk) ser <= '0;
    repeat (3) @(posedge clk);
    pchk(1);
    $display("test serial sharing done");
    @(posedge clk) ext <= 32'hFF;
    kopt <= 1;
    wdir(0, 8'h00);
    repeat (3) @(posedge clk);
    wr(4'hA, 8'h03);
    wr(4'h9, 8'h01);
    #1 chk(pull, 8'hFF);
    pulses = 0;
    @(posedge clk) ext <= 32'hFE;
    repeat (4) @(posedge clk);
    rd(4'h8, 8'h01);
    chk({irq, pulses[6:0]}, 8'h81);
    wr(4'h9, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    wr(4'h9, 8'h01);
    wr(4'hA, 8'h01);
    rd(4'h8, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test keyscan done");
    @(posedge clk) adc_on <= 1;
    wd(2, 8'h5A);
    rd(4'h8, 8'h02);
    wr(4'hB, 8'hFF);
    rd(4'hF, 8'h00);
    $display("test converter and unmapped done");
    stop_test;
  end
endmodule : test_parallel_io_ports
